// ==== src/byte_fifo.sv ====
`timescale 1ns/10ps
`default_nettype none
// Small synchronous FIFO, read data taken combinationally from storage
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  logic push;
  logic pop;
  logic [AW-1:0] rd_next;

  // Handshake terms
  assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign rd_next = (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
  assign out_data = mem_ff[rd_ff];

  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= rd_next;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  fifo_no_overflow_a: assert property (@(posedge clk) disable iff (reset)
    cnt_ff <= (AW+1)'(DEPTH)) else $error("fifo count past depth");
endmodule
`default_nettype wire

// ==== src/serial_engine.sv ====
`timescale 1ns/10ps
`default_nettype none
// How it works
// RULE_01: The engine exists only on channels flagged as engine capable.
// RULE_02: Commands arrive in the downstream byte stream and are decoded.
// RULE_03: With divider zero, one bit moves per serial clock period.
// RULE_04: Serial clock has equal halves, slowed by a command divider. Code holds the low half one cycle longer (ST_DONE).
// RULE_05: Mode value 2 enters engine mode, value 0 resets the mode.
// RULE_06: In adaptive mode clock is raised, data held until echo returns.
// RULE_07: Adaptive clocking is off after reset until a command enables it.
// RULE_08: Without valid config the channel starts as async serial.
// RULE_09: Engine drives clock, data out, select; samples data in; 4 GPIO.
// RULE_10: Any reset returns the channel to async serial mode.
// RULE_11: With adaptive clocking on, line 3 is input only.
module serial_engine
#(
  parameter bit ENGINE_CAPABLE = 1'b1,
  parameter int HALF_CYCLES = serial_engine_pkg::HALF_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_valid,
  output logic cmd_ready,
  output logic [7:0] rsp_data,
  output logic rsp_valid,
  input wire logic rsp_ready,
  output logic engine_mode,
  output logic adaptive_on,
  output logic serial_clock_pin,
  output logic serial_data_out,
  input wire logic serial_data_in,
  output logic select_out,
  output logic pins_enable,
  input wire logic [serial_engine_pkg::GPIO_W-1:0] gpio_in,
  output logic [serial_engine_pkg::GPIO_W-1:0] gpio_out,
  output logic [serial_engine_pkg::GPIO_W-1:0] gpio_oe
);
  import serial_engine_pkg::*;
  eng_state_t state_ff;
  logic [7:0] cmd_ff;
  logic [7:0] arg_ff;
  logic [7:0] div_ff;
  logic [7:0] cnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] rx_ff;
  logic [3:0] bit_ff;
  logic [GPIO_W-1:0] gval_ff;
  logic [GPIO_W-1:0] gdir_ff;
  logic mode_ff;
  logic adapt_ff;
  logic sclk_ff;
  logic sel_ff;
  logic dout_ff;
  logic [7:0] fifo_in;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic take;
  logic tick;
  logic [7:0] half_load;
  logic returned_clock;

  // ****************************************
  // Command intake and pacing
  // ****************************************
  // RULE_02 stream decode
  assign take = cmd_valid && cmd_ready;
  assign cmd_ready = (state_ff == ST_IDLE) || (state_ff == ST_ARG1) ||
                     (state_ff == ST_ARG2);
  assign returned_clock = gpio_in[RETURNED_CLOCK_LINE];
  // RULE_04 half period from divider
  assign half_load = 8'(HALF_CYCLES) + div_ff - 8'h01;
  assign tick = (cnt_ff == 8'h00);

  // Engine sequencer
  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= ST_IDLE;
      cmd_ff <= 8'h00;
      arg_ff <= 8'h00;
      bit_ff <= 4'h0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (take) begin
            cmd_ff <= cmd_data;
            if (cmd_data == CMD_MODE || cmd_data == CMD_DIV ||
                cmd_data == CMD_SHIFT || cmd_data == CMD_GPIO ||
                cmd_data == CMD_SEL) begin
              state_ff <= ST_ARG1;
            end
          end
        end
        ST_ARG1: begin
          if (take) begin
            arg_ff <= cmd_data;
            bit_ff <= 4'h0;
            if (cmd_ff == CMD_GPIO) begin
              state_ff <= ST_ARG2;
            end else if (cmd_ff == CMD_SHIFT && mode_ff) begin
              state_ff <= ST_LOW;
            end else begin
              state_ff <= ST_IDLE;
            end
          end
        end
        ST_ARG2: begin
          if (take) begin
            state_ff <= ST_IDLE;
          end
        end
        ST_LOW: begin
          if (tick) begin
            state_ff <= adapt_ff ? ST_WAIT_RISE : ST_HIGH;
          end
        end
        // RULE_06 hold data until echo
        ST_WAIT_RISE: begin
          if (returned_clock) begin
            state_ff <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (tick) begin
            bit_ff <= bit_ff + 4'h1;
            state_ff <= adapt_ff ? ST_WAIT_FALL : ST_DONE;
          end
        end
        ST_WAIT_FALL: begin
          if (!returned_clock) begin
            state_ff <= ST_DONE;
          end
        end
        ST_DONE: begin
          if (bit_ff != 4'(BITS_PER_BYTE)) begin
            state_ff <= ST_LOW;
          end else if (fifo_in_ready) begin
            state_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end
  // Half period counter
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_ff <= 8'h00;
    end else if (state_ff == ST_LOW || state_ff == ST_HIGH) begin
      cnt_ff <= tick ? half_load : cnt_ff - 8'h01;
    end else begin
      cnt_ff <= half_load;
    end
  end

  // ****************************************
  // Configuration state
  // ****************************************
  // RULE_05 RULE_10 mode select, reset to async
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_ff <= 1'b0;
    end else if (state_ff == ST_ARG1 && take && cmd_ff == CMD_MODE) begin
      // RULE_01 only on capable channels
      mode_ff <= ENGINE_CAPABLE && (cmd_data == MODE_ENGINE);
    end
  end
  // RULE_07 adaptive off until commanded
  always_ff @(posedge clk) begin
    if (reset) begin
      adapt_ff <= 1'b0;
    end else if (state_ff == ST_IDLE && take) begin
      if (cmd_data == CMD_ADAPT_ON) begin
        adapt_ff <= mode_ff;
      end else if (cmd_data == CMD_ADAPT_OFF) begin
        adapt_ff <= 1'b0;
      end
    end else if (!mode_ff || (state_ff == ST_ARG1 && take &&
                 cmd_ff == CMD_MODE && cmd_data != MODE_ENGINE)) begin
      adapt_ff <= 1'b0;
    end
  end
  // Divider, select and GPIO setup
  always_ff @(posedge clk) begin
    if (reset) begin
      div_ff <= DIV_RESET;
      sel_ff <= SEL_RESET;
      gval_ff <= '0;
      gdir_ff <= '0;
    end else if (take && state_ff == ST_ARG1) begin
      if (cmd_ff == CMD_DIV) begin
        div_ff <= cmd_data;
      end
      if (cmd_ff == CMD_SEL) begin
        sel_ff <= cmd_data[0];
      end
    end else if (take && state_ff == ST_ARG2) begin
      gval_ff <= arg_ff[GPIO_W-1:0];
      gdir_ff <= cmd_data[GPIO_W-1:0];
    end
  end

  // ****************************************
  // Shifter, MSB first
  // ****************************************
  // RULE_03 one bit per clock period
  always_ff @(posedge clk) begin
    if (reset) begin
      sclk_ff <= 1'b0;
      dout_ff <= 1'b0;
      shift_ff <= 8'h00;
      rx_ff <= 8'h00;
    end else begin
      if (state_ff == ST_ARG1 && take && cmd_ff == CMD_SHIFT) begin
        shift_ff <= cmd_data;
        dout_ff <= cmd_data[7];
      end
      if (state_ff == ST_LOW && tick) begin
        sclk_ff <= 1'b1;
        rx_ff <= {rx_ff[6:0], serial_data_in};
      end
      if (state_ff == ST_HIGH && tick) begin
        sclk_ff <= 1'b0;
        shift_ff <= {shift_ff[6:0], 1'b0};
        dout_ff <= shift_ff[6];
      end
    end
  end
  // Received byte into response FIFO
  assign fifo_in = rx_ff;
  assign fifo_in_valid = (state_ff == ST_DONE) &&
                         (bit_ff == 4'(BITS_PER_BYTE));
  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) rsp_fifo (
    .clk(clk), .reset(reset), .in_data(fifo_in), .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready), .out_data(rsp_data), .out_valid(rsp_valid),
    .out_ready(rsp_ready)
  );

  // ****************************************
  // Pins
  // ****************************************
  // RULE_08 RULE_09 pins only in engine mode
  assign engine_mode = mode_ff;
  assign adaptive_on = adapt_ff;
  assign pins_enable = mode_ff;
  assign serial_clock_pin = sclk_ff;
  assign serial_data_out = dout_ff;
  assign select_out = sel_ff;
  assign gpio_out = gval_ff;
  // RULE_11 line 3 input under adaptive
  always_comb begin
    gpio_oe = mode_ff ? gdir_ff : '0;
    if (adapt_ff) begin
      gpio_oe[RETURNED_CLOCK_LINE] = 1'b0;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  adapt_line_input_a: assert property (@(posedge clk) // RULE_11
    disable iff (reset) adapt_ff |-> !gpio_oe[RETURNED_CLOCK_LINE])
    else $error("returned clock line driven");
  data_held_wait_a: assert property (@(posedge clk) // RULE_06
    disable iff (reset) (state_ff == ST_WAIT_RISE) |=> $stable(dout_ff))
    else $error("data changed before echo");
  adapt_needs_mode_a: assert property (@(posedge clk) // RULE_07
    disable iff (reset) adapt_ff |-> mode_ff)
    else $error("adaptive active outside engine mode");
  mode_reset_a: assert property (@(posedge clk) // RULE_10
    reset |=> !mode_ff && !adapt_ff)
    else $error("mode not cleared by reset");
  pins_idle_a: assert property (@(posedge clk) // RULE_09
    disable iff (reset) !mode_ff |-> gpio_oe == '0 && !pins_enable)
    else $error("pins driven outside engine mode");
  mode_enter_a: assert property (@(posedge clk) // RULE_05
    disable iff (reset) (state_ff == ST_ARG1 && take && cmd_ff == CMD_MODE
     && cmd_data == MODE_ENGINE) |=> mode_ff == ENGINE_CAPABLE)
    else $error("mode select ignored");
  clock_rise_a: assert property (@(posedge clk) // RULE_04
    disable iff (reset) (state_ff == ST_LOW && tick) |=> sclk_ff)
    else $error("serial clock did not rise");
  only_capable_a: assert property (@(posedge clk) // RULE_01
    disable iff (reset) !ENGINE_CAPABLE |-> !mode_ff)
    else $error("engine on incapable channel");
  shift_start_a: assert property (@(posedge clk) // RULE_03
    disable iff (reset) (state_ff == ST_ARG1 && take && cmd_ff == CMD_SHIFT
     && mode_ff) |=> state_ff == ST_LOW)
    else $error("shift did not start");
  cmd_decode_a: assert property (@(posedge clk) // RULE_02
    disable iff (reset) (state_ff == ST_IDLE && take && cmd_data == CMD_GPIO)
    |=> state_ff == ST_ARG1)
    else $error("command not decoded");
  cv_shift: cover property (@(posedge clk) fifo_in_valid && fifo_in_ready);
  cv_adapt: cover property (@(posedge clk) state_ff == ST_WAIT_FALL);
  cv_full: cover property (@(posedge clk) !fifo_in_ready);
endmodule
`default_nettype wire

// ==== src/serial_engine_pkg.sv ====
package serial_engine_pkg;
  // ****************************************
  // Command stream encoding
  // ****************************************
  localparam logic [7:0] CMD_MODE = 8'h4D;     // Mode select, arg follows
  localparam logic [7:0] CMD_DIV = 8'h44;      // Clock divider, arg follows
  localparam logic [7:0] CMD_ADAPT_ON = 8'h41;
  localparam logic [7:0] CMD_ADAPT_OFF = 8'h61;
  localparam logic [7:0] CMD_SHIFT = 8'h53;    // Shift one byte, arg follows
  localparam logic [7:0] CMD_GPIO = 8'h47;     // Two args: value, direction
  localparam logic [7:0] CMD_SEL = 8'h43;      // One arg: select level
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] MODE_ENGINE = 8'h02;
  localparam logic [7:0] DIV_RESET = 8'h00;
  localparam logic SEL_RESET = 1'b1;
  localparam int BITS_PER_BYTE = 8;
  localparam int GPIO_W = 4;
  localparam int RETURNED_CLOCK_LINE = 3;
  localparam int FIFO_DEPTH = 4;

  // ****************************************
  // Timing
  // ****************************************
  localparam real SCLK_NOM_NS = 33.33;
  localparam real SCLK_HALF_NS = 16.67;
  localparam real CLK_NS = 50.0;
  // Half period rounds up; never below one cycle
  localparam int HALF_CYC_RAW = int'($ceil(SCLK_HALF_NS / CLK_NS));
  localparam int HALF_CYC = (HALF_CYC_RAW < 1) ? 1 : HALF_CYC_RAW;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ARG1 = 3'b001,
    ST_ARG2 = 3'b010,
    ST_LOW = 3'b011,
    ST_HIGH = 3'b100,
    ST_WAIT_RISE = 3'b101,
    ST_WAIT_FALL = 3'b110,
    ST_DONE = 3'b111
  } eng_state_t;
endpackage

// ==== tb/multi_protocol_sync_serial_engine_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module multi_protocol_sync_serial_engine_tb;
  import serial_engine_pkg::*;
  localparam int H = 1;
  logic clk, reset, cmd_valid, cmd_ready, rsp_valid, rsp_ready;
  logic [7:0] cmd_data, rsp_data, tx_byte, rx_byte;
  logic engine_mode, adaptive_on, sclk, dout, din, sel, pins_enable, returned_clock;
  logic engine_mode_b;
  logic [2:0] echo_dly;
  logic [GPIO_W-1:0] gpio_out, gpio_oe;
  int fails = 0;
  int cmp_count = 0;
  int n;
  // ****************************************
  // Clock, design and target
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  serial_engine #(.ENGINE_CAPABLE(1'b1), .HALF_CYCLES(H)) DUT (
    .clk(clk), .reset(reset), .cmd_data(cmd_data), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
    .rsp_ready(rsp_ready), .engine_mode(engine_mode),
    .adaptive_on(adaptive_on), .serial_clock_pin(sclk),
    .serial_data_out(dout), .serial_data_in(din), .select_out(sel),
    .pins_enable(pins_enable), .gpio_in({returned_clock, 3'h5}),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe)
  );
  serial_target target (
    .clk(clk), .sclk(sclk), .dout(dout), .sel(sel), .tx_byte(tx_byte),
    .echo_dly(echo_dly), .din(din), .returned_clock(returned_clock), .rx_byte(rx_byte)
  );
  // Channel without the engine, fed the same command stream
  serial_engine #(.ENGINE_CAPABLE(1'b0), .HALF_CYCLES(H)) DUT2 (
    .clk(clk), .reset(reset), .cmd_data(cmd_data), .cmd_valid(cmd_valid),
    .cmd_ready(), .rsp_data(), .rsp_valid(), .rsp_ready(1'b0),
    .engine_mode(engine_mode_b), .adaptive_on(), .serial_clock_pin(),
    .serial_data_out(), .serial_data_in(1'b0), .select_out(),
    .pins_enable(), .gpio_in(4'h0), .gpio_out(), .gpio_oe()
  );
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("BAD %s exp %h got %h", what, exp, got);
      fails++;
    end
  endtask
  task automatic summarize();
    $display("Checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic send(logic [7:0] b);
    logic r;
    cmd_data = b;
    cmd_valid = 1'b1;
    for (int i = 0; i < 400; i++) begin
      @(negedge clk);
      r = cmd_ready;
      @(posedge clk);
      #1;
      if (r) return;
    end
    fails++;
    summarize();
  endtask
  task automatic stop();
    cmd_valid = 1'b0;
    @(posedge clk);
    #1;
  endtask
  // Keeps ready high; caller drops it
  task automatic recv(logic [7:0] exp);
    logic v;
    logic [7:0] d;
    rsp_ready = 1'b1;
    for (int i = 0; i < 400; i++) begin
      @(negedge clk);
      v = rsp_valid;
      d = rsp_data;
      @(posedge clk);
      #1;
      if (v) begin
        chk("rsp_data", exp, d);
        return;
      end
    end
    fails++;
    summarize();
  endtask
  // Cycles of the first high phase of the serial clock
  task automatic hi_len(output int n);
    n = 0;
    for (int i = 0; i < 400 && sclk !== 1'b1; i++) @(negedge clk);
    while (sclk === 1'b1 && n < 400) begin
      n++;
      @(negedge clk);
    end
    // Hand back just after a rising edge
    @(posedge clk);
    #1;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    chk("engine_mode", 8'h00, engine_mode);
    chk("adaptive_on", 8'h00, adaptive_on);
    chk("select_out", 8'h01, sel);
    chk("pins_enable", 8'h00, pins_enable);
    chk("gpio_oe", 8'h00, gpio_oe);
  endtask
  task automatic t_refuse();
    send(CMD_SHIFT);
    send(8'hA5);
    stop();
    repeat (40) @(posedge clk);
    #1;
    chk("rsp_valid", 8'h00, rsp_valid);
  endtask
  task automatic t_mode();
    send(CMD_MODE);
    send(MODE_ENGINE);
    send(CMD_SEL);
    send(8'h00);
    send(CMD_DIV);
    send(8'h02);
    stop();
    chk("engine_mode", 8'h01, engine_mode);
    chk("pins_enable", 8'h01, pins_enable);
    chk("select_out", 8'h00, sel);
    chk("engine_mode_b", 8'h00, engine_mode_b);
  endtask
  task automatic t_shift();
    send(CMD_SHIFT);
    send(8'hA5);
    hi_len(n);
    stop();
    chk("high len", H + 2, n[7:0]);
    recv(8'h3C);
    rsp_ready = 1'b0;
    chk("rx_byte", 8'hA5, rx_byte);
  endtask
  task automatic t_adapt();
    send(CMD_DIV);
    send(8'h00);
    send(CMD_ADAPT_ON);
    send(CMD_GPIO);
    send(8'h0A);
    send(8'h0F);
    stop();
    chk("adaptive_on", 8'h01, adaptive_on);
    chk("gpio_out", 8'h0A, gpio_out);
    chk("gpio_oe", 8'h07, gpio_oe);
    echo_dly = 3'h6;
    tx_byte = 8'hC3;
    send(CMD_SHIFT);
    send(8'h96);
    hi_len(n);
    stop();
    chk("echo wait", 8'h01, (n >= 7) ? 8'h01 : 8'h00);
    recv(8'hC3);
    rsp_ready = 1'b0;
    chk("rx_byte", 8'h96, rx_byte);
  endtask
  task automatic t_fifo();
    echo_dly = 3'h0;
    tx_byte = 8'h5A;
    send(CMD_ADAPT_OFF);
    for (int k = 0; k < FIFO_DEPTH + 1; k++) begin
      send(CMD_SHIFT);
      send(8'h11);
    end
    stop();
    repeat (60) @(posedge clk);
    #1;
    chk("adaptive_on", 8'h00, adaptive_on);
    chk("cmd_ready", 8'h00, cmd_ready);
    for (int k = 0; k < FIFO_DEPTH + 1; k++) recv(8'h5A);
    rsp_ready = 1'b0;
    chk("rx_byte", 8'h11, rx_byte);
  endtask
  task automatic t_exit();
    send(CMD_ADAPT_ON);
    send(CMD_MODE);
    send(MODE_RESET);
    stop();
    chk("engine_mode", 8'h00, engine_mode);
    chk("pins_enable", 8'h00, pins_enable);
    chk("adaptive_on", 8'h00, adaptive_on);
    send(CMD_MODE);
    send(MODE_ENGINE);
    send(CMD_ADAPT_ON);
    stop();
    chk("adaptive_on", 8'h01, adaptive_on);
    reset = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    reset = 1'b0;
    chk("engine_mode", 8'h00, engine_mode);
    chk("adaptive_on", 8'h00, adaptive_on);
  endtask
  // Main sequence
  initial begin
    reset = 1'b1;
    cmd_valid = 1'b0;
    cmd_data = 8'h00;
    rsp_ready = 1'b0;
    tx_byte = 8'h3C;
    echo_dly = 3'h0;
    repeat (6) @(posedge clk);
    #1;
    reset = 1'b0;
    t_reset();
    t_refuse();
    t_mode();
    t_shift();
    t_adapt();
    t_fifo();
    t_exit();
    summarize();
  end
endmodule
`default_nettype wire

// ==== tb/serial_target.sv ====
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Serial target with returned clock
// ****************************************
module serial_target (
  input wire logic clk,
  input wire logic sclk,
  input wire logic dout,
  input wire logic sel,
  input wire logic [7:0] tx_byte,
  input wire logic [2:0] echo_dly,
  output logic din,
  output logic returned_clock,
  output logic [7:0] rx_byte
);
  logic [7:0] hist;
  logic [2:0] cnt;
  logic tgl;
  initial begin
    hist = 8'h00;
    cnt = 3'h0;
    tgl = 1'b0;
  end
  // clock echo: history of serial clock, tap picks the delay
  always @(posedge clk) begin
    hist <= {hist[6:0], sclk};
    tgl <= ~tgl;
  end
  assign returned_clock = hist[echo_dly];
  // Capture data out on rising clock
  always @(posedge sclk) begin
    rx_byte <= {rx_byte[6:0], dout};
  end
  // Bit index moves on falling clock, restarts on deselect
  always @(negedge sclk or posedge sel) begin
    if (sel) begin
      cnt <= 3'h0;
    end else begin
      cnt <= cnt + 3'h1;
    end
  end
  // Released line toggles so stale data never looks valid
  assign din = sel ? tgl : tx_byte[3'h7 - cnt];
endmodule
`default_nettype wire
